/* File: core/tccc_pkg.sv */
// shared constants, types and decode functions for the counter control block
package tccc_pkg;

	// ==========================================================
	// register map: one index per control register
	localparam logic [3:0] OFS_CH0    = 4'h0;
	localparam logic [3:0] OFS_CH1    = 4'h1;
	localparam logic [3:0] OFS_CH2    = 4'h2;
	localparam logic [3:0] OFS_CH3    = 4'h3;
	localparam logic [3:0] OFS_CH4    = 4'h4;
	localparam logic [3:0] OFS_CH5_U  = 4'h5;
	localparam logic [3:0] OFS_CH5_V  = 4'h6;
	localparam logic [3:0] OFS_CH5_W  = 4'h7;
	localparam int         NCH        = 8;      // registers in total
	localparam logic [7:0] CTRL_RESET = 8'h00;  // every field resets to 0
	localparam logic [7:0] MASK_CH12  = 8'h7f;  // bit 7 reserved on ch1/2
	localparam logic [7:0] MASK_FULL  = 8'hff;

	// ==========================================================
	// prescaler taps: bit n of a free counter toggles every 2^n
	localparam int         PSC_W      = 10;
	localparam logic [3:0] TAP_DIV4   = 4'h1;
	localparam logic [3:0] TAP_DIV16  = 4'h3;
	localparam logic [3:0] TAP_DIV64  = 4'h5;
	localparam logic [3:0] TAP_DIV256 = 4'h7;
	localparam logic [3:0] TAP_DIV1K  = 4'h9;
	localparam logic [1:0] EDGE_RISE  = 2'b00;
	localparam logic [1:0] EDGE_FALL  = 2'b01;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		KIND_CH0, KIND_CH1, KIND_CH2, KIND_CH34, KIND_CH5
	} tccc_kind_type;

	typedef enum logic [2:0] {
		CLR_NONE, CLR_GRA, CLR_GRB, CLR_GRC, CLR_GRD, CLR_SYNC
	} tccc_clear_type;

	typedef enum logic [1:0] {
		SRC_DIV1, SRC_TAP, SRC_EXT, SRC_CASC
	} tccc_srckind_type;

	typedef struct packed {
		logic [2:0] clear_source_select;   // bits 7..5
		logic [1:0] count_edge_select;     // bits 4..3
		logic [2:0] clock_prescale_select; // bits 2..0
	} tccc_ctrl_type;

	typedef struct packed {
		tccc_srckind_type kind;
		logic [3:0]       tap;  // prescaler bit for SRC_TAP
		logic [1:0]       ext;  // pin a..d for SRC_EXT
	} tccc_src_type;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tccc_bus_type;

	// ==========================================================
	// clear source decode; bit 7 is forced 0 on ch1/2 by the mask
	function automatic tccc_clear_type clear_decode(
		input logic [2:0] c);
		case (c[1:0])
			2'b01:   clear_decode = c[2] ? CLR_GRC : CLR_GRA;
			2'b10:   clear_decode = c[2] ? CLR_GRD : CLR_GRB;
			2'b11:   clear_decode = CLR_SYNC;
			default: clear_decode = CLR_NONE;
		endcase
	endfunction : clear_decode

	// ==========================================================
	// clock source decode per channel kind
	function automatic tccc_src_type src_decode(
		input tccc_kind_type k, input logic [2:0] p);
		src_decode = '{SRC_TAP, TAP_DIV4, 2'd0};
		case (p)
			3'd0: src_decode.kind = SRC_DIV1;
			3'd1: src_decode.tap = TAP_DIV4;
			3'd2: src_decode.tap = TAP_DIV16;
			3'd3: src_decode.tap = TAP_DIV64;
			default: begin
				case (k)
					KIND_CH0: src_decode = '{SRC_EXT, TAP_DIV4, p[1:0]};
					KIND_CH1: begin
						if (p == 3'd6)
							src_decode.tap = TAP_DIV256;
						else if (p == 3'd7)
							src_decode.kind = SRC_CASC;
						else
							src_decode = '{SRC_EXT, TAP_DIV4, p[1:0]};
					end
					KIND_CH2: begin
						if (p == 3'd7)
							src_decode.tap = TAP_DIV1K;
						else
							src_decode = '{SRC_EXT, TAP_DIV4, p[1:0]};
					end
					KIND_CH34: begin
						if (p[1])
							src_decode = '{SRC_EXT, TAP_DIV4, {1'b0, p[0]}};
						else
							src_decode.tap = p[0] ? TAP_DIV1K : TAP_DIV256;
					end
					default: begin
						if (p[1])
							src_decode.kind = SRC_DIV1;
						else
							src_decode.tap = p[0] ? TAP_DIV1K : TAP_DIV256;
					end
				endcase
			end
		endcase
	endfunction : src_decode

endpackage : tccc_pkg

/* File: core/tccc_chan_clk.sv */
// per-channel count enable generator: source select and edge select
`timescale 1ns/100ps
module tccc_chan_clk #(
	parameter tccc_pkg::tccc_kind_type KIND = tccc_pkg::KIND_CH0
) (
	input  wire logic                         clk,        // peripheral clock
	input  wire logic                         rstn,       // async, low
	input  wire tccc_pkg::tccc_ctrl_type      ctrl,       // control reg
	input  wire logic [tccc_pkg::PSC_W-1:0]   presc,      // free divider
	input  wire logic [3:0]                   ext_sync,   // synced pins
	input  wire logic                         casc_pulse, // ch2 ovf/udf
	input  wire logic                         phase_mode, // phase count
	output logic                              count_en    // one-cycle
);
	import tccc_pkg::*;

	// ==========================================================
	// selected source level and its previous value
	tccc_src_type src;         // decoded clock source
	logic         level;       // selected clock level this cycle
	logic         level_prev;  // level one cycle ago
	logic [1:0]   eff_edge;    // edge field as actually applied
	logic         rise;
	logic         fall;
	logic         next_count_en;

	assign src = src_decode(KIND, ctrl.clock_prescale_select);

	// level of the chosen internal tap or synced pin
	always_comb begin
		level = 1'b0;
		if (src.kind == SRC_TAP)
			level = presc[src.tap];
		else if (src.kind == SRC_EXT)
			level = ext_sync[src.ext];
	end

	// edge field only means something on /4 and slower sources
	assign eff_edge = (src.kind == SRC_TAP || src.kind == SRC_EXT) ?
		ctrl.count_edge_select : EDGE_RISE;

	assign rise = level & ~level_prev;
	assign fall = ~level & level_prev;

	// enable decision; phase mode hands counting to its own logic
	always_comb begin
		next_count_en = 1'b0;
		if (phase_mode) begin
			next_count_en = 1'b0;
		end else begin
			case (src.kind)
				SRC_DIV1: next_count_en = 1'b1;
				SRC_CASC: next_count_en = casc_pulse;
				default: begin
					if (eff_edge[1])
						next_count_en = rise | fall;
					else if (eff_edge == EDGE_FALL)
						next_count_en = fall;
					else
						next_count_en = rise;
				end
			endcase
		end
	end

	// history of the selected level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			level_prev <= 1'b0;
		else
			level_prev <= level;
	end

	// registered single-cycle enable, never a derived clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			count_en <= 1'b0;
		else
			count_en <= next_count_en;
	end

	// ==========================================================
	// checks
	sequence s_tap_both_change;
		(src.kind == SRC_TAP) && ctrl.count_edge_select[1] &&
		!phase_mode && (level != level_prev);
	endsequence

	chk_div1_every: assert property (@(posedge clk) disable iff (!rstn)
		(src.kind == SRC_DIV1 && !phase_mode) |=> count_en)
		else $error("undivided source did not count every cycle");

	chk_phase_quiet: assert property (@(posedge clk) disable iff (!rstn)
		phase_mode |=> !count_en)
		else $error("count enable seen in phase counting mode");

	chk_casc_follow: assert property (@(posedge clk) disable iff (!rstn)
		(src.kind == SRC_CASC && !phase_mode) |=> count_en == $past(casc_pulse))
		else $error("cascade enable does not follow channel 2 pulse");

	chk_both_edges: assert property (@(posedge clk) disable iff (!rstn)
		s_tap_both_change |=> count_en)
		else $error("both-edge mode missed an edge");

	chk_fall_only: assert property (@(posedge clk) disable iff (!rstn)
		(src.kind == SRC_TAP && ctrl.count_edge_select == EDGE_FALL &&
		!phase_mode) |=> count_en == $past(fall))
		else $error("falling-edge mode counted on wrong edge");

endmodule : tccc_chan_clk

/* File: core/tccc_top.sv */
// counter control registers and count enable logic for eight counters
// Summary of operation
// - eight 8-bit read/write control registers
// - bits 7..5 choose clear source, reset 000
// - bits 4..3: rising, falling, or both
// - both-edge mode counts every edge
// - phase mode on ch1/2 overrides edges
// - edge choice applies to /4 and slower
// - /1 or cascade counts as reset edge
// - bits 2..0 choose clock, independent per channel
// - clear codes map to none, A-D, sync
// - ch1/2 bit 7 reads zero, ignores writes
// - ch0 clocks: /1, /4, /16, /64, pins a-d
// - ch1 code 111 counts ch2 overflow/underflow
`timescale 1ns/100ps
module tccc_top (
	input  wire logic                 clk,           // peripheral clock
	input  wire logic                 rstn,          // async, low
	input  wire tccc_pkg::tccc_bus_type bus,         // register access
	output logic [7:0]                rdata,         // read data, +1 cycle
	input  wire logic                 ext_clock_in_a, // external clock a
	input  wire logic                 ext_clock_in_b, // external clock b
	input  wire logic                 ext_clock_in_c, // external clock c
	input  wire logic                 ext_clock_in_d, // external clock d
	input  wire logic                 ch2_over_under, // ch2 wrap pulse
	input  wire logic [1:0]           phase_mode,    // ch1, ch2 phase
	output logic [7:0]                count_en,      // per-counter enable
	output tccc_pkg::tccc_clear_type  clear_mode [8] // per-counter clear
);
	import tccc_pkg::*;

	// ==========================================================
	// storage and shared timing
	tccc_ctrl_type    ctrl [NCH];     // control registers
	logic [PSC_W-1:0] presc;          // free-running prescaler
	logic [3:0]       ext_meta;       // first sync stage, read by sync2
	logic [3:0]       ext_sync;       // second sync stage
	logic [3:0]       ext_pins;
	logic             hit;            // address maps to a register

	assign ext_pins = {ext_clock_in_d, ext_clock_in_c,
		ext_clock_in_b, ext_clock_in_a};
	assign hit = (bus.addr <= OFS_CH5_W);

	// writable bit mask; reserved bit 7 on ch1/2 keeps its zero
	function automatic logic [7:0] wmask(input int i);
		wmask = (i == OFS_CH1 || i == OFS_CH2) ? MASK_CH12 : MASK_FULL;
	endfunction : wmask

	// channel kind for each register index
	function automatic tccc_kind_type kind_of(input int i);
		case (i)
			0:       kind_of = KIND_CH0;
			1:       kind_of = KIND_CH1;
			2:       kind_of = KIND_CH2;
			3, 4:    kind_of = KIND_CH34;
			default: kind_of = KIND_CH5;
		endcase
	endfunction : kind_of

	// ==========================================================
	// prescaler; one divider shared so taps stay phase aligned
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			presc <= '0;
		else
			presc <= presc + 1'b1;
	end

	// ==========================================================
	// two-stage synchroniser for the external clock pins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_meta <= '0;
			ext_sync <= '0;
		end else begin
			ext_meta <= ext_pins;
			ext_sync <= ext_meta;
		end
	end

	// ==========================================================
	// per-channel registers, decoders and enable generators
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			// register write; no interlock with counting, software's job
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn)
					ctrl[g] <= tccc_ctrl_type'(CTRL_RESET);
				else if (bus.wr && bus.addr == 4'(g))
					ctrl[g] <= tccc_ctrl_type'(bus.wdata & wmask(g));
			end

			// clear source decode straight from the register
			assign clear_mode[g] = clear_decode(ctrl[g].clear_source_select);

			tccc_chan_clk #(
				.KIND (kind_of(g))
			) u_clk (
				.clk        (clk),
				.rstn       (rstn),
				.ctrl       (ctrl[g]),
				.presc      (presc),
				.ext_sync   (ext_sync),
				.casc_pulse (ch2_over_under),
				.phase_mode ((g == 1) ? phase_mode[0] :
					(g == 2) ? phase_mode[1] : 1'b0),
				.count_en   (count_en[g])
			);
		end
	endgenerate

	// ==========================================================
	// read port; unmapped indices answer zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rdata <= '0;
		else if (bus.rd && hit)
			rdata <= ctrl[bus.addr[2:0]];
		else
			rdata <= '0;
	end

	// ==========================================================
	// checks
	sequence s_write_then_read;
		bus.wr && hit ##1 bus.rd && (bus.addr == $past(bus.addr));
	endsequence

	chk_write_read: assert property (@(posedge clk) disable iff (!rstn)
		s_write_then_read |=> rdata == ($past(bus.wdata, 2) &
		((($past(bus.addr, 2) == OFS_CH1) ||
		($past(bus.addr, 2) == OFS_CH2)) ? MASK_CH12 : MASK_FULL)))
		else $error("read back differs from written value");

	chk_reserved_bit: assert property (@(posedge clk) disable iff (!rstn)
		bus.rd && (bus.addr == OFS_CH1 || bus.addr == OFS_CH2) |=>
		!rdata[7])
		else $error("reserved bit 7 read as one");

	chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
		bus.rd && !hit |=> rdata == 8'h00)
		else $error("unmapped read returned nonzero");

	chk_ext_sync: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |-> ##2 ext_sync == $past(ext_pins, 2))
		else $error("pin synchroniser latency is not two cycles");

	chk_clear_map: assert property (@(posedge clk) disable iff (!rstn)
		ctrl[0].clear_source_select[1:0] == 2'b00 |->
		clear_mode[0] == CLR_NONE)
		else $error("clear disabled code decoded as a source");

	// ==========================================================
	// register file and per-channel checks; these name register
	// bits directly, so a slip in the shared decoders shows here
	sequence s_ch3_idle;
		!(bus.wr && (bus.addr == OFS_CH3));
	endsequence

	sequence s_ch1_cascade;
		(ctrl[1].clock_prescale_select == 3'b111) && !phase_mode[0];
	endsequence

	chk_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
		!bus.rd |=> rdata == 8'h00)
		else $error("read data present without a read strobe");

	chk_write_lands: assert property (@(posedge clk) disable iff (!rstn)
		bus.wr && (bus.addr == OFS_CH0) |=> ctrl[0] == $past(bus.wdata))
		else $error("write to channel 0 did not land");

	chk_reg_holds: assert property (@(posedge clk) disable iff (!rstn)
		s_ch3_idle |=> $stable(ctrl[3]))
		else $error("channel 3 register changed without a write");

	chk_bit7_ch1: assert property (@(posedge clk) disable iff (!rstn)
		bus.wr && (bus.addr == OFS_CH1) |=>
		!ctrl[1].clear_source_select[2])
		else $error("reserved bit 7 of channel 1 took a write");

	chk_bit7_ch2: assert property (@(posedge clk) disable iff (!rstn)
		bus.wr && (bus.addr == OFS_CH2) |=>
		!ctrl[2].clear_source_select[2])
		else $error("reserved bit 7 of channel 2 took a write");

	chk_clear_sync: assert property (@(posedge clk) disable iff (!rstn)
		ctrl[0].clear_source_select[1:0] == 2'b11 |->
		clear_mode[0] == CLR_SYNC)
		else $error("sync clear code not decoded as sync");

	chk_clear_grd: assert property (@(posedge clk) disable iff (!rstn)
		ctrl[3].clear_source_select == 3'b110 |->
		clear_mode[3] == CLR_GRD)
		else $error("clear code 110 not decoded as register d");

	chk_presc_step: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> presc == $past(presc) + 10'h001)
		else $error("prescaler skipped a step");

	chk_cascade_ch1: assert property (@(posedge clk) disable iff (!rstn)
		s_ch1_cascade |=> count_en[1] == $past(ch2_over_under))
		else $error("channel 1 did not follow channel 2 wrap pulse");

	chk_phase_ch2: assert property (@(posedge clk) disable iff (!rstn)
		phase_mode[1] |=> !count_en[2])
		else $error("channel 2 counted in phase counting mode");

	chk_ch5w_div1: assert property (@(posedge clk) disable iff (!rstn)
		ctrl[7].clock_prescale_select[2:1] == 2'b11 |=> count_en[7])
		else $error("undivided source on channel 5 w missed a cycle");

endmodule : tccc_top

/* File: tb/tccc_tb.sv */
// self-checking bench for the counter control registers and count enables
`timescale 1ns/100ps
module testbench;
	import tccc_pkg::*;

	// ==========================================================
	// signals
	logic                 clk;            // peripheral clock
	logic                 rstn;           // async reset, low
	tccc_bus_type         bus;            // register port
	logic [7:0]           rdata;          // read data
	logic [3:0]           ext;            // pins a..d
	logic                 ch2_over_under; // ch2 wrap pulse
	logic [1:0]           phase_mode;     // ch1/ch2 phase mode
	logic [7:0]           count_en;       // enables
	tccc_clear_type       clear_mode [8]; // clear decode
	int                   miscompares;    // mismatches
	int                   compares;       // comparisons made
	int                   cnt;            // pulse count
	logic [7:0]           got;            // read value

	// ==========================================================
	// design under test
	tccc_top DUT (
		.clk            (clk),
		.rstn           (rstn),
		.bus            (bus),
		.rdata          (rdata),
		.ext_clock_in_a (ext[0]),
		.ext_clock_in_b (ext[1]),
		.ext_clock_in_c (ext[2]),
		.ext_clock_in_d (ext[3]),
		.ch2_over_under (ch2_over_under),
		.phase_mode     (phase_mode),
		.count_en       (count_en),
		.clear_mode     (clear_mode)
	);

	// ==========================================================
	// clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	// one-cycle write strobe, released on the following edge
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the taking edge
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rd_reg

	// counts cycles with the chosen enable high, sampled mid-cycle
	task automatic count_pulses(input int idx, input int n, output int c);
		c = 0;
		repeat (n) begin
			@(negedge clk);
			if (count_en[idx] === 1'b1)
				c++;
		end
	endtask : count_pulses

	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		report_and_stop;
	end

	// ==========================================================
	// register rows: index, written value, value read back
	logic [3:0] row_a [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
		4'h8};
	logic [7:0] row_w [9] = '{8'hff, 8'hff, 8'hff, 8'ha5, 8'h5a, 8'hff,
		8'h3c, 8'hc3, 8'hff};
	logic [7:0] row_r [9] = '{8'hff, 8'h7f, 8'h7f, 8'ha5, 8'h5a, 8'hff,
		8'h3c, 8'hc3, 8'h00};
	// clear codes 000..111 on channel 0
	tccc_clear_type clr_exp [8] = '{CLR_NONE, CLR_GRA, CLR_GRB, CLR_SYNC,
		CLR_NONE, CLR_GRC, CLR_GRD, CLR_SYNC};
	// count rows: channel, control value, window, enables expected;
	// each window is a whole number of source periods
	logic [3:0] cnt_ch  [11] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1,
		4'h2, 4'h4, 4'h6, 4'h7};
	logic [7:0] cnt_cfg [11] = '{8'h01, 8'h09, 8'h11, 8'h08, 8'h02, 8'h03,
		8'h06, 8'h1f, 8'h04, 8'h05, 8'h0e};
	int         cnt_len [11] = '{32, 32, 32, 32, 64, 128, 512, 1024, 512,
		1024, 32};
	logic [7:0] cnt_exp [11] = '{8'h08, 8'h08, 8'h10, 8'h20, 8'h04, 8'h02,
		8'h02, 8'h02, 8'h02, 8'h01, 8'h20};

	// ==========================================================
	// main sequence
	initial begin
		miscompares = 0;
		compares = 0;
		rstn = 1'b0;
		bus = '{4'h0, 8'h00, 1'b0, 1'b0};
		ext = 4'h0;
		ch2_over_under = 1'b0;
		phase_mode = 2'b00;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		// table of register accesses, unmapped index last
		for (int i = 0; i < 9; i++) begin
			wr_reg(row_a[i], row_w[i]);
			rd_reg(row_a[i], got);
			check(got, row_r[i]);
		end
		// write then read with no idle cycle between the strobes
		@(posedge clk);
		bus <= '{4'h4, 8'h69, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '{4'h4, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		check(rdata, 8'h69);
		$display("register rows done");
		// second reset in mid-run
		@(posedge clk);
		rstn <= 1'b0;
		@(negedge clk);
		check(count_en, 8'h00);
		check(rdata, 8'h00);
		check(8'(clear_mode[0]), 8'(CLR_NONE));
		@(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(negedge clk);
		check(count_en, 8'hff);
		for (int i = 0; i < 8; i++) begin
			rd_reg(i[3:0], got);
			check(got, 8'h00);
		end
		$display("reset done");
		// clear source decode
		for (int c = 0; c < 8; c++) begin
			wr_reg(4'h0, {c[2:0], 5'h00});
			@(negedge clk);
			check(8'(clear_mode[0]), 8'(clr_exp[c]));
		end
		wr_reg(4'h1, 8'he0);
		@(negedge clk);
		check(8'(clear_mode[1]), 8'(CLR_SYNC));
		wr_reg(4'h3, 8'hc0);
		@(negedge clk);
		check(8'(clear_mode[3]), 8'(CLR_GRD));
		$display("clear decode done");
		// edge selection on the prescaler and on /1
		for (int i = 0; i < 11; i++) begin
			wr_reg(cnt_ch[i], cnt_cfg[i]);
			repeat (4) @(posedge clk);
			count_pulses(cnt_ch[i], cnt_len[i], cnt);
			check(8'(cnt), cnt_exp[i]);
		end
		count_pulses(3, 32, cnt);
		check(8'(cnt), 8'h20);
		$display("edge select done");
		// phase counting on ch1 and ch2 suppresses the prescaler enable
		wr_reg(4'h1, 8'h01);
		wr_reg(4'h2, 8'h01);
		phase_mode <= 2'b11;
		repeat (4) @(posedge clk);
		count_pulses(1, 32, cnt);
		check(8'(cnt), 8'h00);
		count_pulses(2, 32, cnt);
		check(8'(cnt), 8'h00);
		@(posedge clk);
		phase_mode <= 2'b00;
		// cascade from ch2 wraps, edge field ignored
		wr_reg(4'h1, 8'h0f);
		repeat (4) @(posedge clk);
		fork
			repeat (5) begin
				@(posedge clk);
				ch2_over_under <= 1'b1;
				@(posedge clk);
				ch2_over_under <= 1'b0;
				@(posedge clk);
			end
			count_pulses(1, 24, cnt);
		join
		check(8'(cnt), 8'h05);
		$display("phase and cascade done");
		// external pin a on rising edges, then pin d on both edges
		for (int m = 0; m < 2; m++) begin
			wr_reg(4'h0, m ? 8'h17 : 8'h04);
			repeat (4) @(posedge clk);
			fork
				repeat (4) begin
					repeat (4) @(posedge clk);
					ext[m ? 3 : 0] <= 1'b1;
					repeat (4) @(posedge clk);
					ext[m ? 3 : 0] <= 1'b0;
				end
				count_pulses(0, 40, cnt);
			join
			check(8'(cnt), m ? 8'h08 : 8'h04);
		end
		$display("external pin done");
		report_and_stop;
	end

endmodule : testbench
